// >>> design/hedsp_defs.vh
`ifndef HEDSP_DEFS_VH
`define HEDSP_DEFS_VH
`define HEDSP_CHANNELS     128
`define HEDSP_CH_W         7
`define HEDSP_PAT_W        3
`define HEDSP_BIT_OLD      2
`define HEDSP_BIT_MID      1
`define HEDSP_BIT_NEW      0
`define HEDSP_MODE_HIT     2'h0
`define HEDSP_MODE_LEVEL   2'h1
`define HEDSP_MODE_EDGE    2'h2
`define HEDSP_MODE_TEST    2'h3
`define HEDSP_ST_IDLE      1'h0
`define HEDSP_ST_SCAN      1'h1
`endif

// >>> design/hedsp_edge.v
`timescale 1ns/1ps
`include "hedsp_defs.vh"
module hedsp_edge #(
  parameter N = `HEDSP_CHANNELS
) (
  // clock and reset
  input  wire         core_clk,
  input  wire         reset_n,
  // configuration
  input  wire         edge_enable,
  // sampled discriminator data and pipeline input
  input  wire [N-1:0] disc_in,
  output reg  [N-1:0] pipe_out
);
  reg [N-1:0] disc_prev;

  // high-to-low transition gives a single pulse, however long the hit
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      disc_prev <= {N{1'h0}};
      pipe_out  <= {N{1'h0}};
    end else begin
      disc_prev <= disc_in;
      if (edge_enable) begin
        pipe_out <= disc_prev & ~disc_in;
      end else begin
        pipe_out <= disc_in;
      end
    end
  end
endmodule

// >>> design/hedsp_top.v
`timescale 1ns/1ps
`include "hedsp_defs.vh"
module hedsp_top #(
  parameter N    = `HEDSP_CHANNELS,
  parameter CH_W = `HEDSP_CH_W
) (
  // clock and reset
  input  wire                   core_clk,
  input  wire                   reset_n,
  // configuration
  input  wire                   edge_enable,
  input  wire [1:0]             crit_mode,
  // front end
  input  wire [N-1:0]           disc_in,
  output wire [N-1:0]           pipe_out,
  // event patterns from readout buffer, 3 bits per channel
  input  wire                   scan_start,
  input  wire [`HEDSP_PAT_W*N-1:0] event_pat,
  output wire                   scan_busy,
  output reg                    scan_done,
  // compressed data to readout logic
  output reg                    hit_valid,
  output reg  [CH_W-1:0]        hit_chan,
  output reg  [`HEDSP_PAT_W-1:0] hit_pat
);

  // scan states; a single flop holds both
  localparam ST_IDLE = `HEDSP_ST_IDLE;
  localparam ST_SCAN = `HEDSP_ST_SCAN;

  // width of one channel pattern and of a whole captured event
  localparam PAT_W = `HEDSP_PAT_W;
  localparam EVT_W = `HEDSP_PAT_W * N;

  // last channel in counter width; only valid while N is at most 2**CH_W
  localparam integer    LAST_CH_I = N - 1;
  localparam [CH_W-1:0] LAST_CH   = LAST_CH_I[CH_W-1:0];

  // scan state
  reg                  state;
  reg                  next_state;

  // channel counter and its decodes
  reg  [CH_W-1:0]      chan;
  reg  [CH_W-1:0]      next_chan;
  wire                 take;
  wire                 last_chan;
  wire                 scan_end;

  // criterion captured at the take edge
  reg  [1:0]           mode_q;
  reg  [1:0]           next_mode;

  // patterns captured at the take edge
  reg  [EVT_W-1:0]     pat_q;
  reg  [EVT_W-1:0]     next_pat;
  wire [PAT_W-1:0]     cur_pat;
  wire                 cur_match;

  // next values of the one-cycle pulses
  reg                  next_valid;
  reg                  next_done;

  // next values of the forwarded word
  reg  [CH_W-1:0]      next_hit_chan;
  reg  [PAT_W-1:0]     next_hit_pat;

  // edge detector sits between the discriminators and the pipeline
  hedsp_edge #(
    .N (N)
  ) u_edge (
    .core_clk    (core_clk),
    .reset_n     (reset_n),
    .edge_enable (edge_enable),
    .disc_in     (disc_in),
    .pipe_out    (pipe_out)
  );

  // criterion test, oldest bit in the top position
  function crit_match;
    input [1:0]       mode;
    input [PAT_W-1:0] p;
    begin
      case (mode)
        `HEDSP_MODE_HIT:   crit_match = |p;
        `HEDSP_MODE_LEVEL: crit_match = p[`HEDSP_BIT_MID];
        `HEDSP_MODE_EDGE:  crit_match = ~p[`HEDSP_BIT_OLD] & p[`HEDSP_BIT_MID];
        `HEDSP_MODE_TEST:  crit_match = 1'h1;
        default:           crit_match = 1'h0;
      endcase
    end
  endfunction

  // one channel's pattern out of the packed event word
  function [PAT_W-1:0] chan_pat;
    input [EVT_W-1:0] evt;
    input [CH_W-1:0]  idx;
    begin
      chan_pat = evt[idx*PAT_W +: PAT_W];
    end
  endfunction

  // a start is taken only while idle; one given during a scan is dropped
  assign take      = (state == ST_IDLE) & scan_start;
  assign last_chan = (chan == LAST_CH);
  assign scan_busy = (state == ST_SCAN);
  assign scan_end  = scan_busy & last_chan;

  // channel under test and its verdict against the captured criterion
  assign cur_pat   = chan_pat(pat_q, chan);
  assign cur_match = crit_match(mode_q, cur_pat);

  // next state and channel: one channel per clock, no gaps, no early exit
  always @* begin
    next_state = state;
    next_chan  = chan;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = ST_SCAN;
          next_chan  = {CH_W{1'h0}};
        end
      end
      ST_SCAN: begin
        if (last_chan) begin
          next_state = ST_IDLE;
        end else begin
          next_chan = chan + 1'b1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // scan state register
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // channel counter register
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      chan <= {CH_W{1'h0}};
    end else begin
      chan <= next_chan;
    end
  end

  // the event is held unless a scan is being started
  always @* begin
    next_mode = mode_q;
    next_pat  = pat_q;
    if (take) begin
      next_mode = crit_mode;
      next_pat  = event_pat;
    end
  end

  // criterion register; a mode change mid-scan cannot reach the running scan
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_q <= `HEDSP_MODE_HIT;
    end else begin
      mode_q <= next_mode;
    end
  end

  // pattern register; costs a full event of flops but decouples the buffer
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pat_q <= {EVT_W{1'h0}};
    end else begin
      pat_q <= next_pat;
    end
  end

  // pulses: only a matching channel raises hit_valid, others leave no trace
  always @* begin
    next_valid = 1'h0;
    next_done  = scan_end;
    if (scan_busy) begin
      next_valid = cur_match;
    end
  end

  // forwarded word; holds after the pulse so a slow sink may still read it
  always @* begin
    next_hit_chan = hit_chan;
    next_hit_pat  = hit_pat;
    if (scan_busy & cur_match) begin
      next_hit_chan = chan;
      next_hit_pat  = cur_pat;
    end
  end

  // pulse registers, one cycle each
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hit_valid <= 1'h0;
      scan_done <= 1'h0;
    end else begin
      hit_valid <= next_valid;
      scan_done <= next_done;
    end
  end

  // data registers of the forwarded word
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hit_chan <= {CH_W{1'h0}};
      hit_pat  <= {PAT_W{1'h0}};
    end else begin
      hit_chan <= next_hit_chan;
      hit_pat  <= next_hit_pat;
    end
  end
endmodule

// >>> dv/hedsp_checker.sv
`timescale 1ns/1ps
module hedsp_checker #(parameter N = 128, parameter CH_W = 7) (
  input wire core_clk, reset_n, edge_enable, scan_start, scan_busy, scan_done, hit_valid,
  input wire [1:0] crit_mode,
  input wire [N-1:0] disc_in, pipe_out,
  input wire [3*N-1:0] event_pat,
  input wire [CH_W-1:0] hit_chan,
  input wire [2:0] hit_pat
);
  reg [1:0] m;
  reg [3*N-1:0] p;
  // copy of what the scan captured, so late changes must not leak in
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) {m, p} <= 0;
    else if (scan_start && !scan_busy) {m, p} <= {crit_mode, event_pat};
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_edge_fall: assert property (edge_enable && $past(edge_enable) |->
    pipe_out == ($past(disc_in, 2) & ~$past(disc_in))) else $error("edge pulse");
  a_pass_thru: assert property (!$past(edge_enable) |-> pipe_out == $past(disc_in)) else $error("bypass");
  a_one_bit: assert property (edge_enable [*3] |-> (pipe_out & $past(pipe_out)) == 0) else $error("long pulse");
  a_done_time: assert property (scan_start && !scan_busy |-> ##129 scan_done) else $error("done late");
  a_done_end: assert property (scan_done |-> !scan_busy && $past(scan_busy)) else $error("done busy");
  a_chan_up: assert property (hit_valid && $past(hit_valid) |-> hit_chan == $past(hit_chan) + 1) else $error("order");
  a_crit_ok: assert property (hit_valid |-> (m == 0 ? |hit_pat : m == 1 ? hit_pat[1] :
    m == 2 ? hit_pat[2:1] == 2'h1 : 1'h1)) else $error("criterion");
  a_pat_fwd: assert property (hit_valid |-> hit_pat == p[3*hit_chan +: 3]) else $error("pattern");
endmodule
bind hedsp_top hedsp_checker #(.N(N), .CH_W(CH_W)) u_chk (.*);

// >>> dv/hedsp_sink.sv
`timescale 1ns/1ps
// readout side, always ready: counts forwarded words
module hedsp_sink (
  input  wire    core_clk,
  input  wire    hit_valid,
  output integer hits
);
  initial hits = 0;
  always @(posedge core_clk) if (hit_valid) hits <= hits + 1;
endmodule

// >>> dv/hedsp_top_tb_top.sv
`timescale 1ns/1ps
module hedsp_top_tb_top;
  reg core_clk = 0, reset_n = 0, edge_enable = 0, scan_start = 0;
  reg [1:0] crit_mode = 0;
  reg [127:0] disc_in = 0;
  reg [383:0] event_pat = 0;
  wire [127:0] pipe_out;
  wire scan_busy, scan_done, hit_valid;
  integer hits, errors = 0, check_count = 0, i, e, k;
  hedsp_top dut (.core_clk(core_clk), .reset_n(reset_n), .edge_enable(edge_enable), .crit_mode(crit_mode),
    .disc_in(disc_in), .pipe_out(pipe_out), .scan_start(scan_start), .event_pat(event_pat), .scan_busy(scan_busy),
    .scan_done(scan_done), .hit_valid(hit_valid), .hit_chan(), .hit_pat());
  hedsp_sink sink (.core_clk(core_clk), .hit_valid(hit_valid), .hits(hits));
  initial forever #4 core_clk = ~core_clk;
  task chk(input string n, input [31:0] s, x);
    check_count++;
    if (s !== x) begin
      errors++;
      $display("ERROR %s exp %0h got %0h", n, x, s);
    end
  endtask
  task final_report;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // long high then fall on all channels, edge mode then bypass
  task t_edge;
    edge_enable = 1;
    disc_in = ~128'h0;
    e = 0;
    repeat (5) begin
      @(negedge core_clk);
      e += (pipe_out !== 0);
    end
    chk("held", e, 0);
    disc_in = 0;
    k = 0;
    repeat (6) begin
      @(negedge core_clk);
      k++;
      if (pipe_out === ~128'h0) e += k;
      else if (pipe_out !== 0) e += 16;
    end
    chk("pulse", e, 1);
    edge_enable = 0;
    disc_in = {4{32'h5a5a_c3c3}};
    @(negedge core_clk);
    chk("bypass", pipe_out[31:0], 32'h5a5a_c3c3);
    chk("bypass hi", pipe_out[127:96], 32'h5a5a_c3c3);
  endtask
  // mode, patterns and a second start during the scan must not alter the result
  task t_scan(input [1:0] m);
    e = hits;
    for (i = 0; i < 128; i++) e += m == 0 ? |i[2:0] : m == 1 ? i[1] : m == 2 ? i[2:1] == 1 : 1;
    crit_mode = m;
    scan_start = 1;
    @(negedge core_clk);
    crit_mode = ~m;
    event_pat = ~event_pat;
    @(negedge core_clk);
    scan_start = 0;
    for (k = 0; k < 200 && scan_done !== 1; k++) @(negedge core_clk);
    event_pat = ~event_pat;
    if (k == 200) begin
      errors++;
      final_report;
    end else begin
      @(negedge core_clk);
      chk("hits", hits, e);
    end
  endtask
  initial begin
    for (i = 0; i < 128; i++) event_pat[3*i +: 3] = i[2:0];
    repeat (6) @(negedge core_clk);
    reset_n = 1;
    t_edge;
    for (integer m = 0; m < 4; m++) t_scan(m[1:0]);
    final_report;
  end
endmodule
